// ---- testbench/ext_requester.sv ----
/*
 external service requester on the far side of the request input.
 assumes acknowledge low ends the request.
*/
`timescale 1ns/1ns
module ext_requester (
   input  wire logic core_clk,
   input  wire logic nrst,
   input  wire logic fire,
   input  wire logic ack_n,
   output logic      req
);
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         req <= 1'b0;
      end else if (fire) begin
         req <= 1'b1;
      end else if (!ack_n) begin
         req <= 1'b0;
      end
   end
endmodule : ext_requester

// ---- testbench/host_bus_checker.sv ----
/*
 concurrent checks on the host bus interface ports.
 assumes single clock core_clk and async active-low nrst.
*/
`timescale 1ns/1ns
module host_bus_checker
   import host_bus_pkg::*;
(
   input wire logic              core_clk,
   input wire logic              nrst,
   input wire logic              addr_strobe,
   input wire logic              unit_select_n,
   input wire logic              read_n,
   input wire logic              irq_acknowledge_n,
   input wire logic              external_request_in,
   input wire logic              data_oe,
   input wire logic              irq_out,
   input wire logic              wide_mode,
   input wire logic [ADDR_W-1:0] muxed_addr_data_low_lines_out,
   input wire logic [2:0]        data_high_lines_out,
   input wire logic [DATA_W-1:0] reg_out [NUM_REGS]
);
   logic as_q;
   logic cs_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // shadow of the latched select
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         as_q <= 1'b0;
         cs_q <= 1'b1;
      end else begin
         as_q <= addr_strobe;
         if (as_q && !addr_strobe) begin
            cs_q <= unit_select_n;
         end
      end
   end
   sequence s_ack_fall;
      !wide_mode && irq_out && reg_out[IDX_CMD3][CMD3_IAE_BIT]
         && $fell(irq_acknowledge_n);
   endsequence
   a_oe_has_cause: assert property (data_oe |-> !$past(read_n)
      || !$past(irq_acknowledge_n)) else $error("bus driven without cause");
   a_oe_release: assert property (read_n && irq_acknowledge_n |=> !data_oe)
      else $error("bus not released");
   a_read_drives: assert property (!wide_mode && !cs_q && !read_n [*2]
      |-> data_oe) else $error("selected read not driven");
   a_unsel_quiet: assert property (cs_q && irq_acknowledge_n [*3]
      |-> !data_oe) else $error("unselected read drove bus");
   a_irq_no_enable: assert property (reg_out[IDX_IRQ_EN] == RESET_ZERO [*2]
      |-> !irq_out) else $error("irq without enable");
   a_ext_irq_up: assert property (reg_out[IDX_IRQ_EN][EXT_LEVEL]
      && $rose(external_request_in) |-> ##2 irq_out)
      else $error("irq missing");
   a_reset_idle: assert property ($rose(nrst) |-> !irq_out && !data_oe
      && reg_out[IDX_CMD3] == RESET_ZERO) else $error("not idle at reset");
   a_opcode_ack: assert property (s_ack_fall |=> data_oe
      && muxed_addr_data_low_lines_out[2:0] == 3'h7
      && data_high_lines_out[2:1] == 2'h3) else $error("bad restart code");
endmodule : host_bus_checker

// ---- testbench/testbench.sv ----
/*
 self-checking bench for the host bus interface.
 assumes the checker and requester model are compiled first.
*/
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_tests++; if ((e) !== (s)) begin num_errors++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module testbench
   import host_bus_pkg::*;
;
   logic       core_clk = 1'b0, nrst = 1'b1, addr_strobe = 1'b0, oe_q;
   logic       unit_select_n = 1'b1, read_n = 1'b1, write_n = 1'b1;
   logic       irq_acknowledge_n = 1'b1, fire = 1'b0, ext_req;
   logic       data_oe, irq_out, wide_mode;
   logic [7:0] bus_in = 8'h00, bus_w, reg_out [NUM_REGS], w [16];
   logic [4:0] lo_out;
   logic [2:0] hi_out;
   logic [7:0] exp_q [$];
   int         num_errors = 0, n_tests = 0, cyc = 0;
   assign bus_w = data_oe ? {hi_out, lo_out} : bus_in;
   always #50 core_clk = ~core_clk;
   host_bus_if dut (.core_clk(core_clk), .nrst(nrst),
      .addr_strobe(addr_strobe), .unit_select_n(unit_select_n),
      .read_n(read_n), .write_n(write_n),
      .muxed_addr_data_low_lines_in(bus_w[4:0]),
      .data_high_lines_in(bus_w[7:5]), .muxed_addr_data_low_lines_out(lo_out),
      .data_high_lines_out(hi_out), .data_oe(data_oe),
      .irq_acknowledge_n(irq_acknowledge_n), .external_request_in(ext_req),
      .irq_out(irq_out), .reg_out(reg_out), .wide_mode(wide_mode));
   ext_requester partner (.core_clk(core_clk), .nrst(nrst), .fire(fire),
      .ack_n(irq_acknowledge_n), .req(ext_req));
   task automatic complete_run();
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run
   task automatic access(input logic [4:0] a, input logic cs,
                         input logic wr, input logic [7:0] d, input int n);
      @(posedge core_clk);
      addr_strobe <= 1'b1;
      unit_select_n <= cs;
      bus_in <= {3'h0, a};
      @(posedge core_clk);
      addr_strobe <= 1'b0;
      repeat (n) begin
         @(posedge core_clk);
         bus_in <= d;
         write_n <= !wr;
         read_n <= wr;
         repeat (2) @(posedge core_clk);
         write_n <= 1'b1;
         read_n <= 1'b1;
         repeat (2) @(posedge core_clk);
      end
   endtask : access
   task automatic ack_req(input logic raise);
      fire <= raise;
      @(posedge core_clk);
      fire <= 1'b0;
      repeat (3) @(posedge core_clk);
      irq_acknowledge_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      irq_acknowledge_n <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask : ack_req
   // scoreboard on each new bus answer, plus hang guard
   always @(posedge core_clk) begin
      oe_q <= data_oe;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         num_errors++;
         complete_run();
      end
      if (data_oe === 1'b1 && oe_q !== 1'b1) begin
         if (exp_q.size() == 0) `CHK("bus spurious", 1'b0, 1'b1)
         else `CHK("bus data", exp_q.pop_front(), bus_w)
      end
   end
   initial begin
      nrst = 1'b0;
      void'($urandom(32'hE779E38C));
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      foreach (reg_out[i]) `CHK("reset reg", RESET_ZERO, reg_out[i])
      for (int i = 7; i < 15; i++) begin
         w[i] = 8'($urandom);
         access(5'(i), 1'b0, 1'b1, w[i], 1);
         `CHK("written", w[i], reg_out[i])
         exp_q.push_back(w[i]);
         exp_q.push_back(w[i]);
         access(5'(i), 1'b0, 1'b0, ~w[i], 2);
         access(5'(i), 1'b1, 1'b1, ~w[i], 1);
         `CHK("unselected", w[i], reg_out[i])
      end
      access({1'b0, IDX_IRQ_EN}, 1'b0, 1'b1, 8'h80, 1);
      access({1'b0, IDX_CMD3}, 1'b0, 1'b1, 8'hA0, 1);
      `CHK("irq idle", 1'b0, irq_out)
      exp_q.push_back(RST_OPCODE | {2'h0, EXT_LEVEL, 3'h0});
      ack_req(1'b1);
      `CHK("irq cleared", 1'b0, irq_out)
      access({1'b0, IDX_IRQ_ADDR}, 1'b0, 1'b1, 8'h01 << EXT_LEVEL, 1);
      `CHK("irq set", 1'b1, irq_out)
      exp_q.push_back(8'h01 << STATUS_INT_BIT);
      access({1'b0, IDX_STATUS}, 1'b0, 1'b0, 8'h00, 1);
      exp_q.push_back({5'h00, EXT_LEVEL});
      access({1'b0, IDX_IRQ_ADDR}, 1'b0, 1'b0, 8'h00, 1);
      `CHK("irq read clear", 1'b0, irq_out)
      access({1'b0, IDX_CMD1}, 1'b0, 1'b1, 8'h02, 1);
      `CHK("word mode", 1'b1, wide_mode)
      access(5'h0F, 1'b0, 1'b1, 8'h55, 1);
      `CHK("odd select", w[7], reg_out[7])
      access(5'h0E, 1'b0, 1'b1, 8'h55, 1);
      `CHK("word index", 8'h55, reg_out[7])
      ack_req(1'b1);
      exp_q.push_back(VECTOR_BASE + 8'(EXT_LEVEL));
      ack_req(1'b0);
      `CHK("vector clear", 1'b0, irq_out)
      `CHK("pending answers", 0, exp_q.size())
      nrst <= 1'b0;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      foreach (reg_out[i]) `CHK("mid reset", RESET_ZERO, reg_out[i])
      `CHK("irq after reset", 1'b0, irq_out)
      complete_run();
   end
endmodule : testbench
bind host_bus_if host_bus_checker chk (.core_clk(core_clk), .nrst(nrst),
   .addr_strobe(addr_strobe), .unit_select_n(unit_select_n),
   .read_n(read_n), .irq_acknowledge_n(irq_acknowledge_n),
   .external_request_in(external_request_in), .data_oe(data_oe),
   .irq_out(irq_out), .wide_mode(wide_mode), .reg_out(reg_out),
   .muxed_addr_data_low_lines_out(muxed_addr_data_low_lines_out),
   .data_high_lines_out(data_high_lines_out));

// ---- verilog/host_bus_if.sv ----
/*
 multiplexed host bus interface: address latch, register file, read and
 write strobes, interrupt acknowledge with restart opcode or vector.
 assumes all pins synchronous to core_clk; the bidirectional bus is split
 into input, output and output enable.
*/
`timescale 1ns/1ns
// Overview of operation
// RULE1: latch five address bits on strobe fall
// RULE2: register index from bits 0-3 or 1-4
// RULE3: latch select; ignore strobes unless low
// RULE4: drive addressed register while read low
// RULE5: write bus value while write low
// RULE6: acknowledge gives opcode or vector, clears pending
// RULE7: interrupt output high while service needed
// RULE8: external request held until acknowledged or read
// RULE9: idle after reset until reprogrammed
// RULE10: system clock of 1.024 MHz multiples
// RULE11: word mode: bit 0 select, second acknowledge
// RULE12: byte mode: opcode on first acknowledge
// RULE13: latched address held between strobes
module host_bus_if
   import host_bus_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic                 nrst,
   input  wire logic                 addr_strobe,
   input  wire logic                 unit_select_n,
   input  wire logic                 read_n,
   input  wire logic                 write_n,
   input  wire logic [ADDR_W-1:0]    muxed_addr_data_low_lines_in,
   input  wire logic [2:0]           data_high_lines_in,
   output logic      [ADDR_W-1:0]    muxed_addr_data_low_lines_out,
   output logic      [2:0]           data_high_lines_out,
   output logic                      data_oe,
   input  wire logic                 irq_acknowledge_n,
   input  wire logic                 external_request_in,
   output logic                      irq_out,
   output logic      [DATA_W-1:0]    reg_out [NUM_REGS],
   output logic                      wide_mode
);
   ////////////////////////////////////////////////////////////////////////
   logic                  strobe_q;
   logic [ADDR_W-1:0]     addr_q;
   logic                  sel_n_q;
   logic [DATA_W-1:0]     regs_q [NUM_REGS];
   logic [NUM_LEVELS-1:0] pending_q;
   logic                  read_q;
   logic                  write_q;
   logic                  ack_q;
   logic                  ack_phase_q;
   logic [DATA_W-1:0]     rdata_q;
   logic                  drive_q;
   logic [DATA_W-1:0]     bus_in;
   logic [REG_IDX_W-1:0]  idx;
   logic                  selected;
   logic                  any_req;
   logic [LEVEL_W-1:0]    level;
   logic                  ack_fall;
   logic                  ack_emit;
   logic                  rd_fall;
   logic                  wr_active;
   logic                  resp_en;
   logic                  ext_q;
   logic                  ext_rise;

   assign bus_in    = {data_high_lines_in, muxed_addr_data_low_lines_in};
   assign wide_mode = regs_q[IDX_CMD1][CMD1_WIDE_BIT];
   assign resp_en   = regs_q[IDX_CMD3][CMD3_IAE_BIT];
   assign reg_out   = regs_q;

   ////////////////////////////////////////////////////////////////////////
   // address latch on falling strobe, held until next fall
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         strobe_q <= 1'b0;
         addr_q   <= '0;
         sel_n_q  <= 1'b1;
      end else begin
         strobe_q <= addr_strobe;
         if (strobe_q && !addr_strobe) begin
            addr_q  <= muxed_addr_data_low_lines_in; // RULE1 RULE13
            sel_n_q <= unit_select_n;                // RULE3
         end
      end
   end

   // index and select decode
   always_comb begin
      if (wide_mode) begin
         idx      = addr_q[4:1];                     // RULE2
         selected = !sel_n_q && !addr_q[0];          // RULE3 RULE11
      end else begin
         idx      = addr_q[3:0];                     // RULE2
         selected = !sel_n_q;                        // RULE3
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         read_q  <= 1'b1;
         write_q <= 1'b1;
         ack_q   <= 1'b1;
      end else begin
         read_q  <= read_n;
         write_q <= write_n;
         ack_q   <= irq_acknowledge_n;
      end
   end

   assign rd_fall   = read_q && !read_n && selected;
   assign wr_active = !write_n && selected;
   assign ack_fall  = ack_q && !irq_acknowledge_n && resp_en && any_req;
   // byte mode emits on first acknowledge, word mode on second
   assign ack_emit  = ack_fall && (!wide_mode || ack_phase_q); // RULE11 RULE12

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ack_phase_q <= 1'b0;
      end else if (ack_fall) begin
         ack_phase_q <= wide_mode ? !ack_phase_q : 1'b0; // RULE11
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // external request: its rising edge marks the level pending, so a
   // request still high at the acknowledge edge cannot re-arm the level
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ext_q <= 1'b0;
      end else begin
         ext_q <= external_request_in;
      end
   end

   assign ext_rise = external_request_in && !ext_q;  // RULE8

   ////////////////////////////////////////////////////////////////////////
   // register file; reset leaves all cleared and idle
   for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      always_ff @(posedge core_clk or negedge nrst) begin
         if (!nrst) begin
            regs_q[g] <= RESET_ZERO;                 // RULE9
         end else if (wr_active && idx == REG_IDX_W'(g)
                      && g != int'(IDX_IRQ_ADDR)
                      && g != int'(IDX_STATUS)) begin
            regs_q[g] <= bus_in;                     // RULE5
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pending levels; set beats clear
   for (genvar l = 0; l < NUM_LEVELS; l++) begin : g_pend
      always_ff @(posedge core_clk or negedge nrst) begin
         if (!nrst) begin
            pending_q[l] <= 1'b0;
         end else if (l == int'(EXT_LEVEL) && ext_rise) begin
            pending_q[l] <= 1'b1;                    // RULE8
         end else if (wr_active && idx == IDX_IRQ_ADDR
                      && bus_in[l]) begin
            pending_q[l] <= 1'b1;
         end else if ((ack_emit || (rd_fall && idx == IDX_IRQ_ADDR))
                      && level == LEVEL_W'(l)) begin
            pending_q[l] <= 1'b0;                    // RULE6 RULE8
         end
      end
   end

   irq_priority u_prio (
      .pending (pending_q),
      .enable  (regs_q[IDX_IRQ_EN]),
      .any_req (any_req),
      .level   (level)
   );

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= any_req;                         // RULE7
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data and bus drive
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= '0;
         drive_q <= 1'b0;
      end else begin
         if (ack_emit) begin
            if (wide_mode) begin
               rdata_q <= VECTOR_BASE | DATA_W'(level);      // RULE6
            end else begin
               rdata_q <= RST_OPCODE | DATA_W'({level, 3'b000}); // RULE6
            end
            drive_q <= 1'b1;
         end else if (!read_n && selected) begin
            if (idx == IDX_IRQ_ADDR) begin
               // level taken at the read fall; it clears, so hold it after
               if (rd_fall) begin
                  rdata_q <= DATA_W'(level);                 // RULE8
               end
            end else if (idx == IDX_STATUS) begin
               rdata_q <= DATA_W'(any_req) << STATUS_INT_BIT;
            end else begin
               rdata_q <= regs_q[idx];                       // RULE4
            end
            drive_q <= 1'b1;
         end else if (!irq_acknowledge_n && drive_q) begin
            drive_q <= 1'b1;
         end else begin
            drive_q <= 1'b0;                                 // RULE4
         end
      end
   end

   assign muxed_addr_data_low_lines_out = rdata_q[ADDR_W-1:0];
   assign data_high_lines_out           = rdata_q[DATA_W-1:ADDR_W];
   assign data_oe                       = drive_q;
endmodule : host_bus_if

// ---- verilog/host_bus_pkg.sv ----
/*
 package for the multiplexed host bus interface: register map indices,
 interrupt response codes and mode constants.
 assumes nothing of its surroundings.
*/
package host_bus_pkg;
   localparam int          ADDR_W        = 5;
   localparam int          DATA_W        = 8;
   localparam int          REG_IDX_W     = 4;
   localparam int          NUM_REGS      = 16;
   localparam int          LEVEL_W       = 3;
   localparam int          NUM_LEVELS    = 8;
   // register indices
   localparam logic [3:0]  IDX_CMD1      = 4'h0;
   localparam logic [3:0]  IDX_CMD3      = 4'h2;
   localparam logic [3:0]  IDX_IRQ_EN    = 4'h5;
   localparam logic [3:0]  IDX_IRQ_ADDR  = 4'h6;
   localparam logic [3:0]  IDX_STATUS    = 4'hF;
   // command 1 fields
   localparam int          CMD1_WIDE_BIT = 1;
   // command 3 and status fields
   localparam int          CMD3_RST_BIT  = 0;
   localparam int          CMD3_IAE_BIT  = 5;
   localparam int          CMD3_SET_BIT  = 7;
   localparam int          STATUS_INT_BIT = 7;
   // external request is interrupt level 7
   localparam logic [2:0]  EXT_LEVEL     = 3'h7;
   // restart opcode base: 0xC7 | level<<3
   localparam logic [7:0]  RST_OPCODE    = 8'hC7;
   localparam logic [7:0]  VECTOR_BASE   = 8'h40;
   localparam logic [7:0]  RESET_ZERO    = 8'h00;
endpackage : host_bus_pkg

// ---- verilog/irq_priority.sv ----
/*
 fixed priority encoder for the pending interrupt levels.
 assumes pending and enable vectors from the register block.
*/
`timescale 1ns/1ns
module irq_priority
   import host_bus_pkg::*;
(
   input  wire logic [NUM_LEVELS-1:0] pending,
   input  wire logic [NUM_LEVELS-1:0] enable,
   output logic                       any_req,
   output logic [LEVEL_W-1:0]         level
);
   logic [NUM_LEVELS-1:0] active;
   assign active  = pending & enable;
   assign any_req = |active;

   // level 0 highest priority
   always_comb begin
      level = '0;
      for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
         if (active[i]) begin
            level = LEVEL_W'(i);
         end
      end
   end
endmodule : irq_priority
